/* logic/pireg_top.v */
`timescale 1ns/1ns
`include "pireg_defs.vh"

module pireg_top #(
	parameter TICK_CYC = `PIR_TICK_US * `PIR_CLK_MHZ,
	parameter CW       = 15
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	input  wire [15:0] primary_analog_input_i,
	input  wire [15:0] secondary_analog_input_i,
	input  wire [15:0] serial_comm_ref_i,
	input  wire [15:0] option_ref_i,
	input  wire [15:0] speed_cmd_i,
	output wire [15:0] speed_ref_o,
	output wire        loss_do_o,
	output wire        alarm_o,
	output wire        fault_relay_o,
	output wire        coast_stop_o,
	output wire        irq_o
);

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam integer       TICK_M1  = TICK_CYC - 1;
	localparam integer       TI_DEN_I = `PIR_KP_DIV * (`PIR_TI_UNIT_US / `PIR_TICK_US);
	localparam integer       TF_DEN_I = `PIR_TF_UNIT_US / `PIR_TICK_US;
	localparam integer       LT_MUL_I = `PIR_LT_UNIT_US / `PIR_TICK_US;
	localparam integer       KP_DIV_I = `PIR_KP_DIV;
	localparam integer       KO_DIV_I = `PIR_KO_DIV;
	localparam integer       OMAX_I   = `PIR_OUT_MAX;
	localparam integer       PCT_I    = `PIR_PCT_MUL;
	// widths fixed here so the loop arithmetic never pads or cuts silently
	localparam [CW-1:0]      TICK_LAST = TICK_M1[CW-1:0];
	localparam signed [47:0] TI_DEN  = {16'h0000, TI_DEN_I};
	localparam signed [47:0] TF_DEN  = {16'h0000, TF_DEN_I};
	localparam [23:0]        LT_MUL  = LT_MUL_I[23:0];
	localparam signed [47:0] KP_DIV  = {16'h0000, KP_DIV_I};
	localparam signed [47:0] KO_DIV  = {16'h0000, KO_DIV_I};
	localparam signed [47:0] OMAX    = {16'h0000, OMAX_I};
	localparam signed [47:0] PCT_MUL = {16'h0000, PCT_I};

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// byte-lane merge of a bus write
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		integer k;
		begin
			wmerge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k])
					wmerge[k*8 +: 8] = nw[k*8 +: 8];
			end
		end
	endfunction

	// sign extension of a 16-bit percent value
	function signed [47:0] sx;
		input [15:0] v;
		begin
			sx = {{32{v[15]}}, v};
		end
	endfunction

	// symmetric clamp, limit assumed non-negative
	function signed [47:0] clamp;
		input signed [47:0] v;
		input signed [47:0] lim;
		begin
			if (v > lim)
				clamp = lim;
			else if (v < -lim)
				clamp = -lim;
			else
				clamp = v;
		end
	endfunction

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	reg  [31:0] ctrl_q, setpt_q, preset_q, gain_q, time_q;
	reg  [31:0] clamp_q, offs_q, losst_q, mask_q;
	reg  [31:0] rdat_q, rd_d;
	reg  [1:0]  stat_q;
	reg         ack_q;
	reg         loss_q, fault_q;
	reg  [15:0] out_q;
	wire [3:0]  idx  = wb_adr_i[5:2];
	wire        hit  = (wb_adr_i[7:6] == 2'h0);
	wire        acc  = wb_cyc_i & wb_stb_i & ~ack_q;
	wire        wr   = acc & wb_we_i & hit;
	wire        rd   = acc & ~wb_we_i;
	wire        fclr = wr & (idx == `PIR_A_CTRL) & wb_sel_i[3] & wb_dat_i[`PIR_F_FRST];
	wire        sclr = rd & hit & (idx == `PIR_A_STAT);
	wire [1:0]  ev;

	// register writes; fault-reset bit is a strobe, never stored
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q   <= `PIR_RST_ZERO;
			setpt_q  <= `PIR_RST_ZERO;
			preset_q <= `PIR_RST_ZERO;
			gain_q   <= `PIR_RST_GAIN;
			time_q   <= `PIR_RST_TIME;
			clamp_q  <= `PIR_RST_CLAMP;
			offs_q   <= `PIR_RST_ZERO;
			losst_q  <= `PIR_RST_LOSST;
			mask_q   <= `PIR_RST_ZERO;
		end else if (wr) begin
			case (idx)
				`PIR_A_CTRL:   ctrl_q   <= wmerge(ctrl_q, wb_dat_i, wb_sel_i) & `PIR_CTRL_RW;
				`PIR_A_SETPT:  setpt_q  <= wmerge(setpt_q, wb_dat_i, wb_sel_i);
				`PIR_A_PRESET: preset_q <= wmerge(preset_q, wb_dat_i, wb_sel_i);
				`PIR_A_GAIN:   gain_q   <= wmerge(gain_q, wb_dat_i, wb_sel_i);
				`PIR_A_TIME:   time_q   <= wmerge(time_q, wb_dat_i, wb_sel_i);
				`PIR_A_CLAMP:  clamp_q  <= wmerge(clamp_q, wb_dat_i, wb_sel_i);
				`PIR_A_OFFS:   offs_q   <= wmerge(offs_q, wb_dat_i, wb_sel_i);
				`PIR_A_LOSST:  losst_q  <= wmerge(losst_q, wb_dat_i, wb_sel_i);
				`PIR_A_MASK:   mask_q   <= wmerge(mask_q, wb_dat_i, wb_sel_i);
				default:       ctrl_q   <= ctrl_q;
			endcase
		end
	end

	// read mux; unmapped words read zero
	always @* begin
		rd_d = `PIR_RST_ZERO;
		if (hit) begin
			case (idx)
				`PIR_A_CTRL:   rd_d = ctrl_q;
				`PIR_A_SETPT:  rd_d = setpt_q;
				`PIR_A_PRESET: rd_d = preset_q;
				`PIR_A_GAIN:   rd_d = gain_q;
				`PIR_A_TIME:   rd_d = time_q;
				`PIR_A_CLAMP:  rd_d = clamp_q;
				`PIR_A_OFFS:   rd_d = offs_q;
				`PIR_A_LOSST:  rd_d = losst_q;
				`PIR_A_STAT:   rd_d = {22'h00_0000, fault_q, loss_q, 6'h00, stat_q};
				`PIR_A_MASK:   rd_d = mask_q;
				`PIR_A_OUT:    rd_d = {16'h0000, out_q};
				default:       rd_d = `PIR_RST_ZERO;
			endcase
		end
	end

	// one wait state, ack dropped the cycle after it is given
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= `PIR_RST_ZERO;
		end else begin
			ack_q <= acc;
			if (rd)
				rdat_q <= rd_d;
		end
	end

	// sticky events; a new event beats the read that clears
	always @(posedge clk_i) begin
		if (rst_i)
			stat_q <= 2'h0;
		else
			stat_q <= (sclr ? 2'h0 : stat_q) | ev;
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign irq_o    = |(stat_q & mask_q[1:0]);

	// ----------------------------------------------------------------
	// update tick
	// ----------------------------------------------------------------
	reg  [CW-1:0] tcnt_q;
	wire          tick = (tcnt_q == TICK_LAST);

	// free-running divider, one enable pulse per update period
	always @(posedge clk_i) begin
		if (rst_i || tick)
			tcnt_q <= {CW{1'b0}};
		else
			tcnt_q <= tcnt_q + {{(CW-1){1'b0}}, 1'b1};
	end

	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	wire [1:0]  mode  = ctrl_q[`PIR_F_MODE];
	wire [4:0]  secf  = ctrl_q[`PIR_F_SECF];
	wire [1:0]  lresp = ctrl_q[`PIR_F_LRESP];
	wire        diff  = (secf == `PIR_SECF_DIFF); // RQ8
	wire        fbsel = (secf == `PIR_SECF_FB); // RQ16
	wire        act   = (mode != `PIR_MODE_OFF) && (diff || fbsel); // RQ2
	wire [15:0] kp    = gain_q[`PIR_F_LO];
	wire [15:0] ko    = gain_q[`PIR_F_HI];
	wire [15:0] ti    = time_q[`PIR_F_LO];
	wire [15:0] tf    = time_q[`PIR_F_HI];
	wire signed [47:0] icl = {32'h0000_0000, clamp_q[`PIR_F_LO]};
	wire signed [47:0] ocl = {32'h0000_0000, clamp_q[`PIR_F_HI]};
	wire signed [47:0] off = sx(offs_q[`PIR_F_LO]);
	reg  [15:0] sp;

	// setpoint priority: stored, serial register, then reference select
	always @* begin
		if (ctrl_q[`PIR_F_SRCSEL])
			sp = setpt_q[`PIR_F_LO]; // RQ1
		else if (ctrl_q[`PIR_F_SERB])
			sp = setpt_q[`PIR_F_HI]; // RQ1
		else begin
			case (ctrl_q[`PIR_F_REF])
				2'h0:    sp = preset_q[`PIR_F_LO]; // RQ1
				2'h1:    sp = primary_analog_input_i;
				2'h2:    sp = serial_comm_ref_i;
				default: sp = option_ref_i;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// loop arithmetic, fractions held in the low bits
	// ----------------------------------------------------------------
	reg  signed [47:0] i_q, y_q;
	wire signed [47:0] a1 = sx(primary_analog_input_i);
	wire signed [47:0] a2 = sx(secondary_analog_input_i);
	wire signed [47:0] e0 = diff ? off - (a1 - a2) : sx(sp) - a2; // RQ8
	wire signed [47:0] er = ctrl_q[`PIR_F_DIR] ? -e0 : e0; // RQ10
	wire signed [47:0] kp48 = {32'h0000_0000, kp};
	wire signed [47:0] ko48 = {32'h0000_0000, ko};
	wire signed [47:0] pt = (er * kp48) / KP_DIV; // RQ3
	wire signed [47:0] ti48 = {32'h0000_0000, ti};
	wire signed [47:0] tden = (ti == 16'h0000) ? TI_DEN : ti48 * TI_DEN;
	// division by the time setting: slow path, but only once per tick
	wire signed [47:0] inc = ((er <<< `PIR_FRAC) * kp48) / tden; // RQ4
	wire signed [47:0] i_d = (ti == 16'h0000) ? 48'sh0000_0000_0000 :
		clamp(i_q + inc, icl <<< `PIR_FRAC); // RQ5
	wire signed [47:0] pi = clamp((pt <<< `PIR_FRAC) + i_d, OMAX <<< `PIR_FRAC);
	wire signed [47:0] tf48 = {32'h0000_0000, tf};
	wire signed [47:0] y_d = (tf == 16'h0000) ? pi :
		y_q + (pi - y_q) / (tf48 * TF_DEN); // RQ9
	wire signed [47:0] g  = ((y_d >>> `PIR_FRAC) * ko48) / KO_DIV; // RQ11
	wire signed [47:0] gc = clamp(g, ocl); // RQ6
	wire signed [47:0] go = diff ? gc : gc + off; // RQ7
	wire signed [47:0] sc = sx(speed_cmd_i);
	reg  signed [47:0] v;

	// place regulator output in the speed path
	always @* begin
		case (mode)
			`PIR_MODE_DIR:  v = go; // RQ2
			`PIR_MODE_TRIM: v = sc + go; // RQ2
			default:        v = sc;
		endcase
		if (!act)
			v = sc;
		else if (!ctrl_q[`PIR_F_REVP] && v < 48'sh0000_0000_0000)
			v = 48'sh0000_0000_0000; // RQ12
		if (fault_q)
			v = 48'sh0000_0000_0000; // RQ14
		v = clamp(v, OMAX);
	end

	// state advances only on the tick; idle loop restarts from zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			i_q   <= 48'sh0000_0000_0000;
			y_q   <= 48'sh0000_0000_0000;
			out_q <= 16'h0000;
		end else if (tick) begin // RQ17
			i_q   <= act ? i_d : 48'sh0000_0000_0000;
			y_q   <= act ? y_d : 48'sh0000_0000_0000;
			out_q <= v[15:0];
		end
	end

	assign speed_ref_o = out_q;

	// ----------------------------------------------------------------
	// feedback loss supervision
	// ----------------------------------------------------------------
	reg  [23:0] lcnt_q;
	wire        len   = (lresp != `PIR_LR_OFF); // RQ14
	wire signed [47:0] llev = {40'h00_0000_0000, offs_q[`PIR_F_LLEV]} * PCT_MUL;
	wire        low   = (a2 < llev);
	wire [23:0] ltgt  = losst_q[23:0] * LT_MUL;
	wire [23:0] lnext = (lcnt_q == 24'hFF_FFFF) ? lcnt_q : lcnt_q + 24'h00_0001;
	wire        loss_d = len && low && (lnext >= ltgt);
	wire        fset  = loss_d && (lresp == `PIR_LR_FAULT);

	// any tick with feedback above level restarts the count
	always @(posedge clk_i) begin
		if (rst_i) begin
			lcnt_q <= 24'h00_0000;
			loss_q <= 1'b0;
		end else if (tick) begin
			lcnt_q <= (len && low) ? lnext : 24'h00_0000; // RQ15
			loss_q <= loss_d; // RQ15
		end
	end

	// fault latches; a new loss beats a simultaneous reset request
	always @(posedge clk_i) begin
		if (rst_i)
			fault_q <= 1'b0;
		else if (tick && fset)
			fault_q <= 1'b1; // RQ14
		else if (fclr)
			fault_q <= 1'b0;
	end

	assign ev[0] = tick & loss_d & ~loss_q;
	assign ev[1] = tick & fset & ~fault_q;

	assign loss_do_o     = loss_q; // RQ13
	assign alarm_o       = loss_q & (lresp == `PIR_LR_ALARM); // RQ14
	assign fault_relay_o = fault_q; // RQ14
	assign coast_stop_o  = fault_q;

endmodule // pireg_top

/* logic/pireg_defs.vh */
// Summary of operation
// (RQ1) setpoint: stored value, else serial setpoint, else reference select 0..3
// (RQ2) mode 0 off, 1 output drives speed, 3 output trims speed command
// (RQ3) error times proportional gain, 0.00..25.00, default 2.00
// (RQ4) integral time up to 360.0 s, default 5.0 s, zero disables integral
// (RQ5) integral term clamped to 0.0..100.0 percent, default 100.0
// (RQ6) total output clamped to 0.0..100.0 percent, default 100.0
// (RQ7) signed offset added to output each update outside differential mode
// (RQ8) function 16 regulates primary minus secondary, offset is target difference
// (RQ9) first-order low-pass filter, 0.00..10.00 s, default zero
// (RQ10) direction 1 inverts the regulator action
// (RQ11) output gain 0.0..25.0, default 1.0
// (RQ12) while regulating, negative output blocked unless reverse permitted
// (RQ13) feedback loss drives a digital output while detection enabled
// (RQ14) response 1 alarm keeps running, 2 coasts and asserts fault relay
// (RQ15) loss only after feedback below level continuously for loss time
// (RQ16) feedback taken from secondary input only with function code B
// (RQ17) all loop arithmetic runs once per fixed update tick
`ifndef PIREG_DEFS_VH
`define PIREG_DEFS_VH

// ----------------------------------------------------------------
// register word indexes
// ----------------------------------------------------------------
`define PIR_A_CTRL    4'h0
`define PIR_A_SETPT   4'h1
`define PIR_A_PRESET  4'h2
`define PIR_A_GAIN    4'h3
`define PIR_A_TIME    4'h4
`define PIR_A_CLAMP   4'h5
`define PIR_A_OFFS    4'h6
`define PIR_A_LOSST   4'h7
`define PIR_A_STAT    4'h8
`define PIR_A_MASK    4'h9
`define PIR_A_OUT     4'hA

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define PIR_F_MODE    1:0
`define PIR_F_SRCSEL  4
`define PIR_F_REF     9:8
`define PIR_F_DIR     12
`define PIR_F_REVP    13
`define PIR_F_SERB    14
`define PIR_F_LRESP   17:16
`define PIR_F_SECF    28:24
`define PIR_F_FRST    31
`define PIR_F_LO      15:0
`define PIR_F_HI      31:16
`define PIR_F_LLEV    23:16
`define PIR_CTRL_RW   32'h1F03_7313

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PIR_RST_ZERO  32'h0000_0000
`define PIR_RST_GAIN  32'h000A_00C8
`define PIR_RST_TIME  32'h0000_0032
`define PIR_RST_CLAMP 32'h03E8_03E8
`define PIR_RST_LOSST 32'h0000_000A

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define PIR_MODE_OFF  2'h0
`define PIR_MODE_DIR  2'h1
`define PIR_MODE_TRIM 2'h3
`define PIR_SECF_FB   5'h0B
`define PIR_SECF_DIFF 5'h10
`define PIR_LR_OFF    2'h0
`define PIR_LR_ALARM  2'h1
`define PIR_LR_FAULT  2'h2

// ----------------------------------------------------------------
// timing and scaling
// ----------------------------------------------------------------
`define PIR_CLK_MHZ   25
`define PIR_TICK_US   1000
`define PIR_TI_UNIT_US 100000
`define PIR_TF_UNIT_US 10000
`define PIR_LT_UNIT_US 100000
`define PIR_KP_DIV    100
`define PIR_KO_DIV    10
`define PIR_PCT_MUL   10
`define PIR_FRAC      16
`define PIR_OUT_MAX   32767

`endif

/* dv/pireg_chk_properties.sv */
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module pireg_chk #(parameter TICK_CYC = 10) (
	input        clk_i,
	input        rst_i,
	input        wb_cyc_i,
	input        wb_stb_i,
	input        wb_we_i,
	input [7:0]  wb_adr_i,
	input [31:0] wb_dat_o,
	input        wb_ack_o,
	input [15:0] speed_ref_o,
	input        loss_do_o,
	input        alarm_o,
	input        fault_relay_o,
	input        coast_stop_o
);
	reg [15:0] cnt_q;
	// tick phase copy, zero just after the update edge
	always @(posedge clk_i)
		cnt_q <= (rst_i || cnt_q == TICK_CYC - 1) ? 16'h0000 : cnt_q + 16'h0001;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_hold; $changed(wb_dat_o) |-> wb_ack_o; endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[7:6] != 2'h0
		|=> wb_dat_o == 32'h0000_0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_ref; $changed(speed_ref_o) |-> cnt_q == 16'h0000; endproperty
	a_ref: assert property (p_ref) else $error("speed moved off tick");
	property p_loss; $changed(loss_do_o) |-> cnt_q == 16'h0000; endproperty
	a_loss: assert property (p_loss) else $error("loss moved off tick");
	property p_alarm; alarm_o |-> loss_do_o && !fault_relay_o; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm without loss");
	property p_coast; coast_stop_o == fault_relay_o; endproperty
	a_coast: assert property (p_coast) else $error("coast and relay differ");
	property p_frise; $rose(fault_relay_o) |-> loss_do_o; endproperty
	a_frise: assert property (p_frise) else $error("fault without loss");
	property p_fclr; $fell(fault_relay_o) |-> $past(wb_cyc_i) && $past(wb_we_i); endproperty
	a_fclr: assert property (p_fclr) else $error("fault cleared without write");
	property p_fzero; fault_relay_o && $past(fault_relay_o, 2) && cnt_q == 16'h0000
		|-> speed_ref_o == 16'h0000; endproperty
	a_fzero: assert property (p_fzero) else $error("speed while faulted");
endmodule // pireg_chk
bind pireg_top pireg_chk #(.TICK_CYC(TICK_CYC)) pireg_chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .speed_ref_o(speed_ref_o),
	.loss_do_o(loss_do_o), .alarm_o(alarm_o), .fault_relay_o(fault_relay_o),
	.coast_stop_o(coast_stop_o));

/* dv/pireg_xdcr.sv */
`timescale 1ns/1ns
// ----------------------------------------
// analog transmitters
// ----------------------------------------
module pireg_xdcr (
	input             clk_i,
	input             lost_i,
	input      [15:0] pri_i,
	input      [15:0] sec_i,
	output reg [15:0] pri_o,
	output reg [15:0] sec_o
);
	// sampled sensors; a broken loop reads zero, not the last value
	always @(posedge clk_i) begin
		pri_o <= pri_i;
		sec_o <= lost_i ? 16'h0000 : sec_i;
	end
endmodule // pireg_xdcr

/* dv/pi_process_regulator_tb_top.sv */
`timescale 1ns/1ns
module pi_process_regulator_tb_top;
	localparam T = 10;
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         cyc_q = 1'b0;
	reg         we_q = 1'b0;
	reg         lost_q = 1'b0;
	reg  [7:0]  adr_q = 8'h00;
	reg  [31:0] wd_q = 32'h0000_0000;
	reg  [31:0] rnd = 32'hf850_38f1;
	reg  [15:0] cmd_q = 16'h0000;
	reg  [15:0] ser_q = 16'h0000;
	reg  [15:0] opt_q = 16'h0000;
	reg  [31:0] expq [$];
	reg  [31:0] c;
	reg  [31:0] g;
	reg  [31:0] o;
	reg  [31:0] t;
	reg  [15:0] e;
	wire [31:0] rd;
	wire [15:0] pri_w;
	wire [15:0] sec_w;
	wire [15:0] sref;
	wire        ack;
	wire        loss;
	wire        alarm;
	wire        fault;
	wire        coast;
	wire        irq;
	integer     failures = 0;
	integer     checks_done = 0;
	integer     k;
	// ----------------------------------------
	// parts
	// ----------------------------------------
	pireg_xdcr pireg_xdcr_i (.clk_i(clk_i), .lost_i(lost_q), .pri_i(16'd500), .sec_i(16'd100),
		.pri_o(pri_w), .sec_o(sec_w));
	pireg_top #(.TICK_CYC(T)) pireg_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_q),
		.wb_stb_i(cyc_q), .wb_we_i(we_q), .wb_adr_i(adr_q), .wb_sel_i(4'hF), .wb_dat_i(wd_q),
		.wb_dat_o(rd), .wb_ack_o(ack), .primary_analog_input_i(pri_w),
		.secondary_analog_input_i(sec_w), .serial_comm_ref_i(ser_q), .option_ref_i(opt_q),
		.speed_cmd_i(cmd_q), .speed_ref_o(sref), .loss_do_o(loss), .alarm_o(alarm),
		.fault_relay_o(fault), .coast_stop_o(coast), .irq_o(irq));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial forever #20 clk_i = ~clk_i;
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// control word; drs is serial bit, reverse permit, direction
	function [31:0] ctl(input [1:0] m, input s, input [1:0] rf, input [2:0] drs,
		input [1:0] lr, input [4:0] f);
		ctl = {3'h0, f, 6'h00, lr, 1'b0, drs, 2'h0, rf, 3'h0, s, 2'h0, m};
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d failures %0d", checks_done, failures);
			if (failures == 0 && checks_done > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// classic cycle: hold until ack is sampled, then release
	task bus(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clk_i);
			cyc_q <= 1'b1;
			we_q <= w;
			adr_q <= a;
			wd_q <= d;
			n = 0;
			do begin
				@(posedge clk_i);
				n = n + 1;
			end while (ack !== 1'b1 && n < 50);
			if (n >= 50)
				failures = failures + 1;
			cyc_q <= 1'b0;
		end
	endtask
	task rdx(input [7:0] a, input [31:0] x);
		begin
			expq.push_back(x);
			bus(1'b0, a, 32'h0000_0000);
		end
	endtask
	task ticks(input integer n);
		repeat (n * T) @(posedge clk_i);
	endtask
	// scoreboard: each read answer against the oldest note
	always @(posedge clk_i)
		if (ack === 1'b1 && we_q === 1'b0)
			check(rd, expq.size() > 0 ? expq.pop_front() : 32'hDEAD_BEEF);
	// watchdog
	initial begin
		ticks(2000);
		failures = failures + 1;
		test_done;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rnd = lfsr(rnd);
		cmd_q <= {7'h00, rnd[8:0]};
		ser_q <= {7'h00, rnd[20:12]};
		opt_q <= {7'h00, rnd[31:23]};
		rdx(8'h0C, 32'h000A_00C8);
		rdx(8'h10, 32'h0000_0032);
		rdx(8'h14, 32'h03E8_03E8);
		rdx(8'h1C, 32'h0000_000A);
		rdx(8'h40, 32'h0000_0000);
		bus(1'b1, 8'h04, {16'd700, 16'd300});
		bus(1'b1, 8'h08, 32'd400);
		bus(1'b1, 8'h14, {16'd1000, 16'd3});
		// feedback 100, primary 500; stored setpoint 300
		for (k = 0; k < 17; k = k + 1) begin
			g = {16'd10, 16'd100};
			o = 32'h0;
			t = 32'h0;
			c = ctl(1, 1, 0, 3'h2, 0, 5'h0B);
			case (k)
			0: begin o = 50; e = 250; end
			1: begin o = 50; c = ctl(1, 1, 0, 3'h1, 0, 5'h0B); e = 0; end
			2: begin o = 50; c = ctl(1, 1, 0, 3'h3, 0, 5'h0B); e = -150; end
			3: begin g = {16'd10, 16'd200}; e = 400; end
			4: begin g = {16'd25, 16'd100}; e = 500; end
			5: begin g = {16'd10, 16'd2500}; e = 1000; end
			6: begin c = ctl(3, 1, 0, 3'h2, 0, 5'h0B); e = 200 + cmd_q; end
			7: begin c = ctl(0, 1, 0, 3'h2, 0, 5'h0B); e = cmd_q; end
			8: begin c = ctl(1, 1, 0, 3'h2, 0, 5'h00); e = cmd_q; end
			9: begin o = 100; c = ctl(1, 1, 0, 3'h2, 0, 5'h10); e = -300; end
			10: begin c = ctl(1, 0, 0, 3'h6, 0, 5'h0B); e = 600; end
			11: begin c = ctl(1, 0, 0, 3'h2, 0, 5'h0B); e = 300; end
			12: begin c = ctl(1, 0, 1, 3'h2, 0, 5'h0B); e = 400; end
			13: begin c = ctl(1, 0, 2, 3'h2, 0, 5'h0B); e = ser_q - 100; end
			14: begin c = ctl(1, 0, 3, 3'h2, 0, 5'h0B); e = opt_q - 100; end
			15: begin t = {16'd1, 16'd0}; e = 199; end
			default: begin t = 32'd1; e = 203; end
			endcase
			bus(1'b1, 8'h00, 32'h0);
			bus(1'b1, 8'h0C, g);
			bus(1'b1, 8'h18, o);
			bus(1'b1, 8'h10, t);
			bus(1'b1, 8'h00, c);
			ticks(k == 15 ? 60 : 4);
			check(sref, e);
			rdx(8'h28, {16'h0000, e});
		end
		// alarm: level 5 percent, no delay, masked then unmasked
		bus(1'b1, 8'h10, 32'h0);
		bus(1'b1, 8'h1C, 32'h0);
		bus(1'b1, 8'h18, {8'h00, 8'd5, 16'h0});
		bus(1'b1, 8'h00, ctl(0, 0, 0, 3'h0, 1, 5'h0B));
		lost_q <= 1'b1;
		ticks(3);
		check(loss, 1);
		check(alarm, 1);
		check(fault, 0);
		check(irq, 0);
		bus(1'b1, 8'h24, 32'h1);
		check(irq, 1);
		lost_q <= 1'b0;
		ticks(3);
		check(loss, 0);
		rdx(8'h20, 32'h1);
		rdx(8'h20, 32'h0);
		check(irq, 0);
		// fault after the full loss time of 100 ticks
		bus(1'b1, 8'h1C, 32'h1);
		bus(1'b1, 8'h00, ctl(1, 1, 0, 3'h2, 2, 5'h0B));
		lost_q <= 1'b1;
		ticks(50);
		check(loss, 0);
		ticks(60);
		check(loss, 1);
		check(fault, 1);
		check(coast, 1);
		check(alarm, 0);
		rdx(8'h28, 32'h0);
		check(sref, 0);
		lost_q <= 1'b0;
		bus(1'b1, 8'h00, 32'h8000_0000 | ctl(1, 1, 0, 3'h2, 2, 5'h0B));
		ticks(2);
		check(fault, 0);
		test_done;
	end
endmodule // pi_process_regulator_tb_top
